// [logic/dlret_consts.vh]
`ifndef DLRET_CONSTS_VH
`define DLRET_CONSTS_VH
// Register byte offsets on the AXI4-Lite bus
`define DLRET_ER_LO   13'h0000
`define DLRET_ER_HI   13'h0004
`define DLRET_EER_LO  13'h0008
`define DLRET_EER_HI  13'h000C
`define DLRET_EMR_LO  13'h0010
`define DLRET_EMR_HI  13'h0014
`define DLRET_ESR_LO  13'h0018
`define DLRET_ESR_HI  13'h001C
`define DLRET_QER     13'h0020
`define DLRET_QCTL    13'h0024
`define DLRET_STAT    13'h0028
// Address bit selecting parameter memory window
`define DLRET_MEM_BIT 12
// Word positions inside one eight-word parameter set
`define DLRET_W_OPT   3'h0
`define DLRET_W_SRC   3'h1
`define DLRET_W_AB    3'h2
`define DLRET_W_DST   3'h3
`define DLRET_W_LINK  3'h5
`define DLRET_W_FRAMES_PER_BLOCK  3'h7
`define DLRET_W_LAST  3'h7
// Options word fields
`define DLRET_OPT_STATIC 3
`define DLRET_OPT_ABSYNC 2
// Reload pointer values
`define DLRET_NULL_LINK 16'hFFFF
`define DLRET_NULL_W5   32'h0000FFFF
`define DLRET_SET_SH    5
// Quick channel control fields
`define DLRET_QC_EN   0
`define DLRET_QC_TW   1
`define DLRET_QC_SET  8
`define DLRET_QCH     7'h40
// Bus responses
`define DLRET_OKAY    2'h0
`define DLRET_SLVERR  2'h2
// Sequencer states
`define DLRET_S_IDLE  3'h0
`define DLRET_S_EVAL  3'h1
`define DLRET_S_TR    3'h2
`define DLRET_S_UPD   3'h3
`define DLRET_S_LINK  3'h4
`endif

// [logic/dlret_top.v]
`timescale 1ns/1ns
`include "dlret_consts.vh"
module dlret_top #(
  parameter SETW = 7              // Parameter sets = 2**SETW
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [12:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [12:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [2:0]  audio0_tx_evt,
  input  wire [2:0]  audio0_rx_evt,
  input  wire [2:0]  audio1_tx_evt,
  input  wire [1:0]  spi_evt,
  input  wire [5:0]  uart_evt,
  input  wire [1:0]  i2c_evt,
  input  wire [10:0] gpio_evt,
  input  wire [4:0]  vcp1_evt,
  input  wire [3:0]  timer_evt,
  input  wire [1:0]  pwm_evt,
  input  wire [6:0]  vcp0_evt,
  input  wire [63:0] chain_evt,
  output reg         tr_valid,
  input  wire        tr_ready,
  output reg  [6:0]  tr_chan,
  output reg  [31:0] tr_opt,
  output reg  [31:0] tr_src,
  output reg  [31:0] tr_dst,
  output reg  [31:0] tr_cnt,
  output reg         tr_final
);
  localparam IW = SETW + 3;       // Parameter memory word index width

  // Set and word to flat memory index
  function [IW-1:0] widx;
    input [SETW-1:0] s;
    input [2:0]      w;
    begin
      widx = {s, w};
    end
  endfunction

  // Byte strobes to a bit mask
  function [31:0] smask;
    input [3:0] s;
    begin
      smask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // Lowest pending channel wins; quick channel last
  function [6:0] pick;
    input [64:0] v;
    integer i;
    begin
      pick = 7'h00;
      for (i = 64; i >= 0; i = i - 1)
        if (v[i])
          pick = i[6:0];
    end
  endfunction

  reg [31:0]     mem [0:(1<<IW)-1];  // Parameter memory, eight words per set
  reg [63:0]     er_r;               // event_latch_reg
  reg [63:0]     eer_r;              // event_enable_reg
  reg [63:0]     emr_r;              // missed_event_reg
  reg [63:0]     man_r;              // Pending writes to event_set_reg
  reg [63:0]     chn_r;              // Pending chain triggers
  reg [63:0]     evt_q_r;            // Previous event levels, for edge detect
  reg            qer_r;              // quick_event_latch_reg
  reg            qmiss_r;            // Quick channel missed event
  reg [31:0]     qctl_r;             // quick_channel_map and enable
  reg [2:0]      st_r;               // Sequencer state
  reg [6:0]      ch_r;               // Channel in service
  reg [SETW-1:0] set_r;              // Set in service
  reg [SETW-1:0] lsrc_r;             // Reload source set, held through the copy
  reg            lnull_r;            // Reload writes a null set
  reg [2:0]      k_r;                // Reload word counter
  reg            aw_v_r;             // Write address held
  reg [12:0]     aw_a_r;
  reg            w_v_r;              // Write data held
  reg [31:0]     w_d_r;
  reg [3:0]      w_s_r;

  // Fixed map of peripheral events onto channels; gaps stay unused
  wire [63:0] evt = {vcp0_evt, 3'h0, pwm_evt, timer_evt,
                     vcp1_evt, gpio_evt, 2'h0, i2c_evt, 4'h0,
                     uart_evt, spi_evt, 3'h0,
                     audio1_tx_evt, audio0_rx_evt, audio0_tx_evt,
                     4'h0};
  // Rising edge marks one event
  wire [63:0] pe = evt & ~evt_q_r;

  // Fields of the set in service
  wire [31:0] c_opt  = mem[widx(set_r, `DLRET_W_OPT)];
  wire [31:0] c_src  = mem[widx(set_r, `DLRET_W_SRC)];
  wire [31:0] c_ab   = mem[widx(set_r, `DLRET_W_AB)];
  wire [31:0] c_dst  = mem[widx(set_r, `DLRET_W_DST)];
  wire [31:0] c_lk   = mem[widx(set_r, `DLRET_W_LINK)];
  wire [31:0] c_cc   = mem[widx(set_r, `DLRET_W_FRAMES_PER_BLOCK)];
  // Only three counts exist; an element is one array of bytes
  wire [15:0] bytes_per_array   = c_ab[15:0];
  wire [15:0] arrays_per_frame   = c_ab[31:16];
  wire [15:0] frames_per_block   = c_cc[15:0];
  wire [15:0] link   = c_lk[15:0];
  wire [15:0] bcrld  = c_lk[31:16];
  wire [15:0] lsh    = link >> `DLRET_SET_SH;
  wire        absync = c_opt[`DLRET_OPT_ABSYNC];
  wire        hold   = c_opt[`DLRET_OPT_STATIC];
  // Null and dummy classification
  wire        is_null = (bytes_per_array == 16'h0000) && (arrays_per_frame == 16'h0000)
                        && (frames_per_block == 16'h0000);
  wire        is_dmy  = !is_null && ((bytes_per_array == 16'h0000) || (arrays_per_frame == 16'h0000)
                        || (frames_per_block == 16'h0000));
  // Last request of the set; dummy sets end at once
  wire        last   = is_dmy || (absync ? (frames_per_block == 16'h0001)
                       : ((arrays_per_frame == 16'h0001) && (frames_per_block == 16'h0001)));

  // Quick channel map fields
  wire            qen  = qctl_r[`DLRET_QC_EN];
  wire [2:0]      qtw  = qctl_r[`DLRET_QC_TW +: 3];
  wire [SETW-1:0] qset = qctl_r[`DLRET_QC_SET +: SETW];

  // Queue: enabled latched events, manual and chain triggers, quick latch
  wire [64:0] req = {qer_r, (er_r & eer_r) | man_r | chn_r};

  // Consumption of the serviced event, null or submitted
  wire        nul_hit = (st_r == `DLRET_S_EVAL) && is_null;
  wire        tr_done = (st_r == `DLRET_S_TR) && tr_ready;
  wire [64:0] clr     = (nul_hit || tr_done) ? ({64'h0, 1'b1} << ch_r) : 65'h0;
  wire [64:0] nmiss   = nul_hit ? ({64'h0, 1'b1} << ch_r) : 65'h0;

  // Bus write that completes this cycle; memory is locked while the
  // sequencer writes it, which keeps a single writer per cycle
  wire        wr_ok = (st_r != `DLRET_S_UPD) && (st_r != `DLRET_S_LINK);
  wire        wdo   = aw_v_r && w_v_r && !s_axi_bvalid && wr_ok;
  wire [31:0] wm    = smask(w_s_r);
  wire        wmem  = wdo && aw_a_r[`DLRET_MEM_BIT];
  wire [IW-1:0] wmi = aw_a_r[IW+1:2];
  wire        wreg  = wdo && !aw_a_r[`DLRET_MEM_BIT];
  wire [63:0] esr_w = {(wreg && aw_a_r == `DLRET_ESR_HI) ? (w_d_r & wm) : 32'h0,
                       (wreg && aw_a_r == `DLRET_ESR_LO) ? (w_d_r & wm) : 32'h0};
  wire [63:0] emr_w = {(wreg && aw_a_r == `DLRET_EMR_HI) ? (w_d_r & wm) : 32'h0,
                       (wreg && aw_a_r == `DLRET_EMR_LO) ? (w_d_r & wm) : 32'h0};
  wire        qm_w  = wreg && (aw_a_r == `DLRET_QER) && w_d_r[1] && w_s_r[0];

  // Quick trigger: software write or reload copy onto the trigger word
  wire        qtrg_sw = wmem && qen && (wmi == widx(qset, qtw));
  wire        qtrg_lk = (st_r == `DLRET_S_LINK) && qen
                        && (widx(set_r, k_r) == widx(qset, qtw));
  wire        qtrg    = qtrg_sw || qtrg_lk;

  // Handshake outputs; the clock enable freezes acceptance too
  assign s_axi_awready = ce && !aw_v_r;
  assign s_axi_wready  = ce && !w_v_r;
  assign s_axi_arready = ce && !s_axi_rvalid;

  // Event latches and missed flags; a set always beats a clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Nothing pending after reset
      er_r    <= 64'h0;
      emr_r   <= 64'h0;
      man_r   <= 64'h0;
      chn_r   <= 64'h0;
      qer_r   <= 1'b0;
      qmiss_r <= 1'b0;
      evt_q_r <= 64'h0;
    end
    else if (ce)
    begin
      evt_q_r <= evt;
      // Latch whatever the enable says; stays until serviced
      er_r    <= (er_r & ~clr[63:0]) | pe;
      // Three independent trigger sources
      man_r   <= (man_r & ~clr[63:0]) | esr_w;
      chn_r   <= (chn_r & ~clr[63:0]) | chain_evt;
      qer_r   <= (qer_r & ~clr[64]) | qtrg;
      // Repeats before the clear, or a null service, flag a miss
      emr_r   <= (emr_r & ~emr_w) | nmiss[63:0]
                 | (pe & er_r & ~clr[63:0])
                 | (esr_w & man_r & ~clr[63:0])
                 | (chain_evt & chn_r & ~clr[63:0]);
      qmiss_r <= (qmiss_r & ~qm_w) | nmiss[64] | (qtrg & qer_r & ~clr[64]);
    end
  end

  // Service sequencer and transfer request outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r     <= `DLRET_S_IDLE;
      ch_r     <= 7'h00;
      set_r    <= {SETW{1'b0}};
      lsrc_r   <= {SETW{1'b0}};
      lnull_r  <= 1'b0;
      k_r      <= 3'h0;
      tr_valid <= 1'b0;
      tr_chan  <= 7'h00;
      tr_opt   <= 32'h0;
      tr_src   <= 32'h0;
      tr_dst   <= 32'h0;
      tr_cnt   <= 32'h0;
      tr_final <= 1'b0;
    end
    else if (ce)
    begin
      case (st_r)
        `DLRET_S_IDLE:
        begin
          // Head of queue: normal channel n uses set n
          if (|req)
          begin
            ch_r  <= pick(req);
            set_r <= pick(req) == `DLRET_QCH ? qset : pick(req);
            st_r  <= `DLRET_S_EVAL;
          end
        end
        `DLRET_S_EVAL:
        begin
          // Reload source captured now, since a reload may overwrite it
          lsrc_r  <= lsh[SETW-1:0];
          lnull_r <= (link == `DLRET_NULL_LINK);
          k_r     <= 3'h0;
          if (is_null)
            // Discarded; a null set is still reloaded unless held
            st_r <= hold ? `DLRET_S_IDLE : `DLRET_S_LINK;
          else
          begin
            // Alignment of constant addressing is left to the far end
            tr_valid <= 1'b1;
            tr_chan  <= ch_r;
            tr_opt   <= c_opt;
            tr_src   <= c_src;
            tr_dst   <= c_dst;
            tr_cnt   <= absync ? c_ab : {16'h0001, bytes_per_array};
            tr_final <= last;
            st_r     <= `DLRET_S_TR;
          end
        end
        `DLRET_S_TR:
        begin
          // Latch is cleared by the consume term as the request is taken
          if (tr_ready)
          begin
            tr_valid <= 1'b0;
            if (!tr_final)
              st_r <= `DLRET_S_UPD;
            else if (hold)
              st_r <= `DLRET_S_IDLE;
            else
              st_r <= `DLRET_S_LINK;
          end
        end
        `DLRET_S_UPD:
          st_r <= `DLRET_S_IDLE;
        `DLRET_S_LINK:
        begin
          // One word per cycle, all eight of them
          k_r <= k_r + 3'h1;
          if (k_r == `DLRET_W_LAST)
            st_r <= `DLRET_S_IDLE;
        end
        default:
          st_r <= `DLRET_S_IDLE;
      endcase
    end
  end

  // Parameter memory: bus writes, count updates and reload copies.
  // No reset; software must program sets before enabling events.
  always @(posedge aclk)
  begin
    if (ce)
    begin
      if (wmem)
        mem[wmi] <= (mem[wmi] & ~wm) | (w_d_r & wm);
      else if (st_r == `DLRET_S_UPD && !hold)
      begin
        // Count updates between requests of one set
        if (absync)
          mem[widx(set_r, `DLRET_W_FRAMES_PER_BLOCK)] <= {c_cc[31:16], frames_per_block - 16'h0001};
        else if (arrays_per_frame != 16'h0001)
          mem[widx(set_r, `DLRET_W_AB)] <= {arrays_per_frame - 16'h0001, bytes_per_array};
        else
        begin
          mem[widx(set_r, `DLRET_W_AB)]   <= {bcrld, bytes_per_array};
          mem[widx(set_r, `DLRET_W_FRAMES_PER_BLOCK)] <= {c_cc[31:16], frames_per_block - 16'h0001};
        end
      end
      else if (st_r == `DLRET_S_LINK)
      begin
        // Null pointer yields zeros with the pointer kept at FFFFh;
        // self pointer just rewrites each word with itself
        if (lnull_r)
          mem[widx(set_r, k_r)] <= (k_r == `DLRET_W_LINK)
                                   ? `DLRET_NULL_W5 : 32'h0;
        else
          mem[widx(set_r, k_r)] <= mem[widx(lsrc_r, k_r)];
      end
    end
  end

  // Bus slave: write channels, response and control registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_v_r       <= 1'b0;
      aw_a_r       <= 13'h0;
      w_v_r        <= 1'b0;
      w_d_r        <= 32'h0;
      w_s_r        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DLRET_OKAY;
      eer_r        <= 64'h0;
      qctl_r       <= 32'h0;
    end
    else if (ce)
    begin
      // Address and data may arrive in either order
      if (s_axi_awvalid && !aw_v_r)
      begin
        aw_v_r <= 1'b1;
        aw_a_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_v_r)
      begin
        w_v_r <= 1'b1;
        w_d_r <= s_axi_wdata;
        w_s_r <= s_axi_wstrb;
      end
      if (wdo)
      begin
        aw_v_r       <= 1'b0;
        w_v_r        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Read-only and unmapped offsets answer with an error
        if (aw_a_r[`DLRET_MEM_BIT] || aw_a_r == `DLRET_EER_LO
            || aw_a_r == `DLRET_EER_HI || aw_a_r == `DLRET_EMR_LO
            || aw_a_r == `DLRET_EMR_HI || aw_a_r == `DLRET_ESR_LO
            || aw_a_r == `DLRET_ESR_HI || aw_a_r == `DLRET_QER
            || aw_a_r == `DLRET_QCTL)
          s_axi_bresp <= `DLRET_OKAY;
        else
          s_axi_bresp <= `DLRET_SLVERR;
        if (wreg && aw_a_r == `DLRET_EER_LO)
          eer_r[31:0] <= (eer_r[31:0] & ~wm) | (w_d_r & wm);
        if (wreg && aw_a_r == `DLRET_EER_HI)
          eer_r[63:32] <= (eer_r[63:32] & ~wm) | (w_d_r & wm);
        if (wreg && aw_a_r == `DLRET_QCTL)
          qctl_r <= (qctl_r & ~wm) | (w_d_r & wm);
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Bus slave: read channel, one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `DLRET_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DLRET_OKAY;
        if (s_axi_araddr[`DLRET_MEM_BIT])
          s_axi_rdata <= mem[s_axi_araddr[IW+1:2]];
        else
          case (s_axi_araddr)
            `DLRET_ER_LO:  s_axi_rdata <= er_r[31:0];
            `DLRET_ER_HI:  s_axi_rdata <= er_r[63:32];
            `DLRET_EER_LO: s_axi_rdata <= eer_r[31:0];
            `DLRET_EER_HI: s_axi_rdata <= eer_r[63:32];
            `DLRET_EMR_LO: s_axi_rdata <= emr_r[31:0];
            `DLRET_EMR_HI: s_axi_rdata <= emr_r[63:32];
            `DLRET_ESR_LO: s_axi_rdata <= 32'h0;
            `DLRET_ESR_HI: s_axi_rdata <= 32'h0;
            `DLRET_QER:    s_axi_rdata <= {30'h0, qmiss_r, qer_r};
            `DLRET_QCTL:   s_axi_rdata <= qctl_r;
            `DLRET_STAT:   s_axi_rdata <= {22'h0, ch_r, st_r};
            default:
            begin
              // Unmapped register offset
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= `DLRET_SLVERR;
            end
          endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [testbench/dlret_asserts.sv]
`timescale 1ns/1ns
`include "dlret_consts.vh"
module dlret_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        ce,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        tr_valid,
  input wire        tr_ready,
  input wire [6:0]  tr_chan,
  input wire [31:0] tr_opt,
  input wire [31:0] tr_cnt,
  input wire        tr_final
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TR_HOLD:
    assert property (tr_valid && !tr_ready |=> tr_valid && $stable({tr_chan, tr_cnt}))
    else $error("request changed before it was taken");
  AST_TR_ONE:
    assert property (tr_valid && tr_ready |=> !tr_valid)
    else $error("second request right after a take");
  // A reload moves eight words, so no request can follow sooner
  AST_LINK_GAP:
    assert property (tr_valid && tr_ready && tr_final && !tr_opt[`DLRET_OPT_STATIC]
      |=> !tr_valid [*8])
    else $error("request issued during reload");
  AST_RST_IDLE:
    assert property ($rose(aresetn) |-> !tr_valid && !s_axi_bvalid && !s_axi_rvalid)
    else $error("activity right after reset");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_BOUND:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:12] s_axi_bvalid)
    else $error("write response late");
  AST_R_LAT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_AR_BLOCK:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  AST_CE_FREEZE:
    assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus accepted while frozen");

  // Main scenarios reached
  COV_FINAL: cover property (tr_valid && tr_ready && tr_final);
  COV_QUICK: cover property (tr_valid && tr_ready && tr_chan == `DLRET_QCH);
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind dlret_top dlret_asserts u_chk (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tr_valid, .tr_ready, .tr_chan, .tr_opt,
  .tr_cnt, .tr_final
);

// [testbench/dlret_tc_model.sv]
`timescale 1ns/1ns
module dlret_tc_model (
  input  wire aclk,
  input  wire aresetn,
  input  wire slow,
  input  wire tr_valid,
  output reg  tr_ready
);
  reg [1:0] dly_r; // Cycles spent on the present request

  // Ready comes a cycle after valid, or four in slow mode; it never precedes valid
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tr_ready <= 1'b0;
      dly_r    <= 2'h0;
    end
    else if (tr_valid && tr_ready)
    begin
      tr_ready <= 1'b0;
      dly_r    <= 2'h0;
    end
    else if (tr_valid)
    begin
      dly_r    <= dly_r + 2'h1;
      tr_ready <= !slow || (dly_r == 2'h3);
    end
  end
endmodule

// [testbench/tb_dma_link_reload_and_event_trigger.sv]
`timescale 1ns/1ns
`include "dlret_consts.vh"
module tb_dma_link_reload_and_event_trigger;
  reg         aclk, aresetn, ce, slow;       // Clock, reset, enable, partner pace
  reg  [12:0] s_axi_awaddr, s_axi_araddr;    // Bus addresses
  reg  [31:0] s_axi_wdata, rd, c_src, c_cnt, c_opt, c_dst; // Write data, read, captured request
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, tr_opt, tr_src, tr_dst, tr_cnt;
  wire        tr_valid, tr_ready, tr_final;
  wire [6:0]  tr_chan;
  reg  [6:0]  c_chan;     // Channel of last taken request
  reg         c_fin;      // Final flag of last taken request
  reg  [47:0] ev;         // Every peripheral event line, in port order
  reg  [63:0] chain_evt;  // Chain triggers
  int         n_fail = 0, num_checks = 0, n_tr = 0;

  dlret_top dut_u (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .audio0_tx_evt(ev[2:0]), .audio0_rx_evt(ev[5:3]), .audio1_tx_evt(ev[8:6]),
    .spi_evt(ev[10:9]), .uart_evt(ev[16:11]), .i2c_evt(ev[18:17]), .gpio_evt(ev[29:19]),
    .vcp1_evt(ev[34:30]), .timer_evt(ev[38:35]), .pwm_evt(ev[40:39]), .vcp0_evt(ev[47:41]),
    .chain_evt, .tr_valid, .tr_ready, .tr_chan, .tr_opt, .tr_src, .tr_dst, .tr_cnt, .tr_final
  );
  dlret_tc_model tc_u (.aclk, .aresetn, .slow, .tr_valid, .tr_ready);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Capture each request as the far side takes it
  always @(posedge aclk)
    if (tr_valid && tr_ready)
    begin
      n_tr   <= n_tr + 1;
      c_chan <= tr_chan;
      c_src  <= tr_src;
      c_opt  <= tr_opt;
      c_dst  <= tr_dst;
      c_cnt  <= tr_cnt;
      c_fin  <= tr_final;
    end

  task end_sim;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        n_fail++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // Address and data go out together; each drops once taken
  task axi_wr(input [12:0] a, input [31:0] d, input [1:0] er);
    int t;
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (t = 0; t < 200 && !(s_axi_bvalid && s_axi_bready); t++)
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
    end
  endtask

  task axi_rd(input [12:0] a, input [1:0] er);
    int t;
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (t = 0; t < 200 && !(s_axi_rvalid && s_axi_rready); t++)
      begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      chk("rresp", er, s_axi_rresp);
    end
  endtask

  task rchk(input string nm, input [12:0] a, input [31:0] e);
    begin
      axi_rd(a, `DLRET_OKAY);
      chk(nm, e, rd);
    end
  endtask

  // Write a whole set, or read it back word by word; destination equals source
  task set_io(input bit wr, input [6:0] s, input [31:0] o, sr, ab, lk, cc);
    reg [31:0] v [8];
    int        w;
    begin
      v = '{o, sr, ab, sr, 0, lk, 0, cc};
      for (w = 0; w < 8; w++)
        if (wr)
          axi_wr({1'b1, s, w[2:0], 2'b00}, v[w], `DLRET_OKAY);
        else
          rchk("set word", {1'b1, s, w[2:0], 2'b00}, v[w]);
    end
  endtask

  // Polls status until the sequencer rests; gives a pending service time to start
  task idle;
    int t;
    begin
      repeat (4) @(posedge aclk);
      rd = 1;
      for (t = 0; t < 30 && rd[2:0] != 3'h0; t++)
        axi_rd(`DLRET_STAT, `DLRET_OKAY);
    end
  endtask

  task wait_tr(input int n);
    int t;
    begin
      for (t = 0; t < 400 && n_tr < n; t++)
        @(posedge aclk);
      chk("requests", n, n_tr);
      idle;
    end
  endtask

  // One rising edge on every event line at once
  task pulse;
    begin
      @(posedge aclk);
      ev <= 48'hFFFFFFFFFFFF;
      @(posedge aclk);
      ev <= 48'h0;
      repeat (2) @(posedge aclk);
    end
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #400000;
    n_fail++;
    end_sim;
  end

  initial
  begin
    {ce, aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h20;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {ev, chain_evt} = 0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("event latch", `DLRET_ER_LO, 32'h0);
    axi_rd(13'h002C, `DLRET_SLVERR);
    axi_wr(`DLRET_ER_LO, 32'h1, `DLRET_SLVERR);
    // All sources latch while disabled; a repeat is a miss
    pulse;
    rchk("map low", `DLRET_ER_LO, 32'h30FF1FF0);
    rchk("map high", `DLRET_ER_HI, 32'hFE3FFFFF);
    pulse;
    rchk("missed low", `DLRET_EMR_LO, 32'h30FF1FF0);
    rchk("missed high", `DLRET_EMR_HI, 32'hFE3FFFFF);
    axi_wr(`DLRET_EMR_LO, 32'hFFFFFFFF, `DLRET_OKAY);
    axi_wr(`DLRET_EMR_HI, 32'hFFFFFFFF, `DLRET_OKAY);
    rchk("missed clear", `DLRET_EMR_LO, 32'h0);
    chk("no request", 0, n_tr);
    // Enabling a latched channel serves it; hold bit blocks the reload
    set_io(1, 4, 32'hC, 32'h100, 32'h00020010, 32'hFFFF, 1);
    axi_wr(`DLRET_EER_LO, 32'h10, `DLRET_OKAY);
    wait_tr(1);
    chk("chan", 4, c_chan);
    chk("counts", 32'h00020010, c_cnt);
    rchk("latch cleared", `DLRET_ER_LO, 32'h30FF1FE0);
    set_io(0, 4, 32'hC, 32'h100, 32'h00020010, 32'hFFFF, 1);
    // Link chain: set 1 reloads from set 100, then ends in a null set
    set_io(1, 100, 32'h4, 32'h200, 32'h00010008, 32'hFFFF, 2);
    set_io(1, 1, 32'h4, 32'h300, 32'h00010004, 32'h0C80, 1);
    axi_wr(`DLRET_ESR_LO, 32'h2, `DLRET_OKAY);
    wait_tr(2);
    set_io(0, 1, 32'h4, 32'h200, 32'h00010008, 32'hFFFF, 2);
    axi_wr(`DLRET_ESR_LO, 32'h2, `DLRET_OKAY);
    wait_tr(3);
    chk("not final", 0, c_fin);
    rchk("count only", 13'h103C, 32'h1);
    axi_wr(`DLRET_ESR_LO, 32'h2, `DLRET_OKAY);
    wait_tr(4);
    chk("final", 1, c_fin);
    set_io(0, 1, 32'h0, 32'h0, 32'h0, 32'hFFFF, 0);
    axi_wr(`DLRET_ESR_LO, 32'h2, `DLRET_OKAY);
    idle;
    chk("null dropped", 4, n_tr);
    rchk("null missed", `DLRET_EMR_LO, 32'h2);
    axi_wr(`DLRET_EMR_LO, 32'h2, `DLRET_OKAY);
    // Self link under a slow far side: one-shot set, reloaded after each request
    slow <= 1'b1;
    set_io(1, 2, 32'h4, 32'h400, 32'h00010004, 32'h0040, 1);
    chain_evt <= 64'h4;
    @(posedge aclk);
    chain_evt <= 64'h0;
    wait_tr(5);
    axi_wr(`DLRET_ESR_LO, 32'h4, `DLRET_OKAY);
    wait_tr(6);
    set_io(0, 2, 32'h4, 32'h400, 32'h00010004, 32'h0040, 1);
    slow <= 1'b0;
    // Quick channel on set 120, whose reload from 121 fires it again
    set_io(1, 121, 32'hC, 32'h500, 32'h00010004, 32'hFFFF, 1);
    axi_wr(`DLRET_QCTL, 32'h0000780F, `DLRET_OKAY);
    set_io(1, 120, 32'h4, 32'h600, 32'h00010004, 32'h0F20, 1);
    wait_tr(8);
    chk("quick chan", `DLRET_QCH, c_chan);
    chk("quick src", 32'h500, c_src);
    chk("quick opt", 32'hC, c_opt);
    chk("quick dst", 32'h500, c_dst);
    // Dummy set: one final request, no miss
    set_io(1, 3, 32'h8, 32'h700, 32'h00000004, 32'hFFFF, 1);
    axi_wr(`DLRET_ESR_LO, 32'h8, `DLRET_OKAY);
    wait_tr(9);
    chk("dummy final", 1, c_fin);
    chk("dummy counts", 32'h00010004, c_cnt);
    rchk("dummy no miss", `DLRET_EMR_LO, 32'h0);
    // Frozen clock enable closes the bus
    ce <= 1'b0;
    @(posedge aclk);
    chk("frozen", 0, s_axi_arready);
    ce <= 1'b1;
    end_sim;
  end
endmodule
